// >>> rtl/ccr_pkg.sv
// Package of constants and carriers for the comparator control register bank
package ccr_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned N_CMP = 3;

    // ------------------------------------------------------------------
    // Register byte offsets and decode indices
    // ------------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL1  = 8'h00;
    localparam logic [ADR_W-1:0] OFS_CTRL2  = 8'h04;
    localparam logic [ADR_W-1:0] OFS_CTRL3  = 8'h08;
    localparam logic [ADR_W-1:0] OFS_ECON1  = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_ECON2  = 8'h10;
    localparam logic [ADR_W-1:0] OFS_ECON3  = 8'h14;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADR_W-1:0] OFS_MASK   = 8'h1C;

    localparam logic [3:0] IDX_CTRL1  = 4'h0;
    localparam logic [3:0] IDX_ECON1  = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h6;
    localparam logic [3:0] IDX_MASK   = 4'h7;
    localparam logic [3:0] IDX_NONE   = 4'hF;

    // ------------------------------------------------------------------
    // Field positions, write masks and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_ON         = 7;
    localparam int unsigned BIT_IRQ_ON     = 6;
    localparam int unsigned STAT_FLAG_LSB  = 5;
    localparam int unsigned STAT_LEVEL_LSB = 1;
    localparam logic [7:0]  CTRL_WMASK     = 8'hF7;
    localparam logic [7:0]  CTRL3_WMASK    = 8'hFF;
    localparam logic [7:0]  ECON1_WMASK    = 8'h3F;
    localparam logic [7:0]  ECON_WMASK     = 8'h37;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  ECON_RST       = 8'h00;
    localparam logic [2:0]  MASK_RST       = 3'h7;

    // ------------------------------------------------------------------
    // Sensitivity and negative input codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SENSE_TOGGLE = 2'h0;
    localparam logic [1:0] SENSE_RSVD   = 2'h1;
    localparam logic [1:0] SENSE_FALL   = 2'h2;
    localparam logic [1:0] SENSE_RISE   = 2'h3;
    localparam logic [2:0] NEG_BANDGAP  = 3'h4;
    localparam logic [2:0] NEG_DAC      = 3'h5;
    localparam logic [2:0] NEG_OWN_PIN  = 3'h6;
    localparam logic [2:0] NEG_SHARED   = 3'h7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       on;
        logic       irq_on;
        logic [1:0] sense;
        logic       alt_pin_on;
        logic [2:0] negsel;
    } ccr_ctrl_s;

    typedef struct packed {
        logic [1:0] spare;
        logic       out_invert;
        logic       out_pin_on;
        logic       capture_route;
        logic [2:0] hyst;
    } ccr_econ_s;

    typedef struct packed {
        logic       on;
        logic       ladder_sel;
        logic       bandgap_sel;
        logic       dac_sel;
        logic       own_negative_pin;
        logic       shared_negative_pin;
        logic [2:0] negsel;
        logic [2:0] hyst;
    } ccr_ana_s;

    typedef struct packed {
        logic val;
        logic oe;
    } ccr_pin_s;

    typedef struct packed {
        ccr_ctrl_s [N_CMP-1:0] ctrl;
        ccr_econ_s [N_CMP-1:0] econ;
        logic [N_CMP-1:0]      flag;
        logic [N_CMP-1:0]      mask;
        logic [DAT_W-1:0]      rdata;
    } ccr_state_s;

    typedef struct packed {
        logic ack;
    } ccr_wbst_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ccr_syncst_s;

endpackage

// >>> rtl/ccr_wb_if.sv
// Wishbone classic handshake: access strobe and single-cycle acknowledge
module ccr_wb_if
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic wb_cyc_i,
    input  wire logic wb_stb_i,
    output logic      acc_o,
    output logic      wb_ack_o
);
    import ccr_pkg::*;

    ccr_wbst_s st;
    ccr_wbst_s next_st;

    // Ack gaps the request so a held strobe is taken at most every other cycle
    always_comb begin
        next_st     = st;
        acc_o       = wb_cyc_i && wb_stb_i && !st.ack;
        next_st.ack = acc_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;

    ack_follows_acc_a: assert property (@(posedge clk_i) disable iff (rst_i) acc_o |=> wb_ack_o)
        else $error("ack missing one cycle after access");
    ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

// >>> rtl/ccr_sync_edge.sv
// Two-flop synchroniser with edge detection for one comparator output
module ccr_sync_edge
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    import ccr_pkg::*;

    ccr_syncst_s st;
    ccr_syncst_s next_st;

    // First stage feeds only the second; edges come from stages two and three
    always_comb begin
        next_st    = st;
        next_st.s1 = raw_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.s2;
    assign rise_o  = st.s2 && !st.s3;
    assign fall_o  = !st.s2 && st.s3;

    level_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> level_o == $past(raw_i, 2))
        else $error("level is not the input two cycles back");
    single_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise_o || fall_o) |=> !(rise_o || fall_o) || $past(raw_i, 2) != $past(raw_i, 3))
        else $error("one transition gave two edge pulses");

endmodule

// >>> rtl/ccr_top.sv
// Comparator control register bank: Wishbone registers, event flags and analog controls
// Contract
// - Control bit 7 powers each comparator
// - Control bit 6 gates comparator interrupt
// - Code 00 toggles; code 01 reserved
// - Code 10 triggers on falling edge
// - Code 11 triggers on rising edge
// - Select 000-011 pick reference ladder taps
// - Select 100 bandgap, 101 converter output
// - Select 110 own pin, 111 shared pin
// - Comparator 3 bit 3 drives alternate pin
// - One status register holds levels, flags
// - Extended register: invert, pin, capture, hysteresis
// - Flag set on event, cleared two ways
// - Capture bit routes comparator 1 to timer
// - Invert bit inverts comparator output
// - Level bit mirrors comparator output
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
module ccr_top
(
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_i,
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [ccr_pkg::ADR_W-1:0]            wb_adr_i,
    input  wire logic [ccr_pkg::SEL_W-1:0]            wb_sel_i,
    input  wire logic [ccr_pkg::DAT_W-1:0]            wb_dat_i,
    output logic      [ccr_pkg::DAT_W-1:0]            wb_dat_o,
    output logic                                      wb_ack_o,
    input  wire logic [ccr_pkg::N_CMP-1:0]            cmp_raw_i,
    input  wire logic [ccr_pkg::N_CMP-1:0]            vec_ack_i,
    output ccr_pkg::ccr_ana_s [ccr_pkg::N_CMP-1:0]    ana_o,
    output ccr_pkg::ccr_pin_s [ccr_pkg::N_CMP-1:0]    out_pin_o,
    output ccr_pkg::ccr_pin_s                         alt_pin_o,
    output logic                                      capture_route_o,
    output logic                                      capture_o,
    output logic      [ccr_pkg::N_CMP-1:0]            cmp_irq_o,
    output logic                                      irq_o
);
    import ccr_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] reg_index(input logic [ADR_W-1:0] adr);
        logic [3:0] idx;
        idx = IDX_NONE;
        if (adr == OFS_CTRL1) begin
            idx = IDX_CTRL1;
        end else if (adr == OFS_CTRL2) begin
            idx = 4'(IDX_CTRL1 + 4'h1);
        end else if (adr == OFS_CTRL3) begin
            idx = 4'(IDX_CTRL1 + 4'h2);
        end else if (adr == OFS_ECON1) begin
            idx = IDX_ECON1;
        end else if (adr == OFS_ECON2) begin
            idx = 4'(IDX_ECON1 + 4'h1);
        end else if (adr == OFS_ECON3) begin
            idx = 4'(IDX_ECON1 + 4'h2);
        end else if (adr == OFS_STATUS) begin
            idx = IDX_STATUS;
        end else if (adr == OFS_MASK) begin
            idx = IDX_MASK;
        end
        return idx;
    endfunction

    function automatic logic edge_hit(input logic [1:0] sense, input logic rise, input logic fall);
        logic hit;
        hit = 1'b0;
        case (sense)
            SENSE_TOGGLE: hit = rise || fall;
            SENSE_FALL:   hit = fall;
            SENSE_RISE:   hit = rise;
            default:      hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic ccr_ana_s ana_map(input ccr_ctrl_s c, input ccr_econ_s e);
        ccr_ana_s a;
        a                     = '0;
        a.on                  = c.on;
        a.negsel              = c.negsel;
        a.ladder_sel          = !c.negsel[2];
        a.bandgap_sel         = c.negsel == NEG_BANDGAP;
        a.dac_sel             = c.negsel == NEG_DAC;
        a.own_negative_pin    = c.negsel == NEG_OWN_PIN;
        a.shared_negative_pin = c.negsel == NEG_SHARED;
        a.hyst                = e.hyst;
        return a;
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake and decode
    // ------------------------------------------------------------------
    ccr_state_s       st;
    ccr_state_s       next_st;
    logic             acc;
    logic [3:0]       idx;
    logic             wr;
    logic             rd;
    logic [N_CMP-1:0] lvl;
    logic [N_CMP-1:0] rise;
    logic [N_CMP-1:0] fall;
    logic [N_CMP-1:0] hit;
    logic [N_CMP-1:0] clr;
    logic [7:0]       rbyte;

    ccr_wb_if u_wb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .acc_o    (acc),
        .wb_ack_o (wb_ack_o)
    );

    assign idx = reg_index(wb_adr_i);
    // Registers sit in byte lane 0; a write without that lane is acked and dropped
    assign wr  = acc && wb_we_i && wb_sel_i[0];
    assign rd  = acc && !wb_we_i;

    // ------------------------------------------------------------------
    // Comparator output conditioning
    // ------------------------------------------------------------------
    // Flipping the invert bit moves the level, so it may raise an event
    for (genvar g = 0; g < N_CMP; g++) begin : g_sync
        ccr_sync_edge u_sync (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .raw_i   (cmp_raw_i[g] ^ st.econ[g].out_invert),
            .level_o (lvl[g]),
            .rise_o  (rise[g]),
            .fall_o  (fall[g])
        );
        assign hit[g] = st.ctrl[g].on && edge_hit(st.ctrl[g].sense, rise[g], fall[g]);
    end

    // ------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        clr     = '0;
        rbyte   = 8'h00;
        for (int i = 0; i < N_CMP; i++) begin
            if (wr && idx == 4'(IDX_CTRL1 + 4'(i))) begin
                next_st.ctrl[i] = wb_dat_i[7:0] & ((i == N_CMP - 1) ? CTRL3_WMASK : CTRL_WMASK);
            end
            if (wr && idx == 4'(IDX_ECON1 + 4'(i))) begin
                next_st.econ[i] = wb_dat_i[7:0] & ((i == 0) ? ECON1_WMASK : ECON_WMASK);
            end
            // Vector clears only while enabled; an event in the same cycle wins
            clr[i] = (wr && idx == IDX_STATUS && wb_dat_i[STAT_FLAG_LSB + i])
                   || (vec_ack_i[i] && st.ctrl[i].irq_on);
            if (clr[i]) begin
                next_st.flag[i] = 1'b0;
            end
            if (hit[i]) begin
                next_st.flag[i] = 1'b1;
            end
        end
        if (wr && idx == IDX_MASK) begin
            next_st.mask = wb_dat_i[STAT_FLAG_LSB +: N_CMP];
        end
        if (idx == IDX_STATUS) begin
            rbyte = {st.flag, 1'b0, lvl, 1'b0};
        end else if (idx == IDX_MASK) begin
            rbyte = {st.mask, 5'h00};
        end else if (idx >= IDX_ECON1 && idx < IDX_STATUS) begin
            rbyte = st.econ[2'(idx - IDX_ECON1)];
        end else if (idx < IDX_ECON1) begin
            rbyte = st.ctrl[2'(idx)];
        end
        if (rd) begin
            next_st.rdata = {24'h00_0000, rbyte};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.ctrl  <= {N_CMP{CTRL_RST}};
            st.econ  <= {N_CMP{ECON_RST}};
            st.flag  <= '0;
            st.mask  <= MASK_RST;
            st.rdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o = st.rdata;

    for (genvar o = 0; o < N_CMP; o++) begin : g_out
        assign ana_o[o]         = ana_map(st.ctrl[o], st.econ[o]);
        assign out_pin_o[o].val = lvl[o];
        assign out_pin_o[o].oe  = st.econ[o].out_pin_on;
        assign cmp_irq_o[o]     = st.flag[o] && st.ctrl[o].irq_on;
    end

    assign alt_pin_o.val    = lvl[N_CMP-1];
    assign alt_pin_o.oe     = st.ctrl[N_CMP-1].alt_pin_on;
    assign capture_route_o  = st.econ[0].capture_route;
    assign capture_o        = st.econ[0].capture_route && lvl[0];
    // Software should drop irq_on or the pin before sampling a shared input
    assign irq_o            = |(cmp_irq_o & st.mask);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_status_clear(int k);
        wr && idx == IDX_STATUS && wb_dat_i[STAT_FLAG_LSB + k] && !hit[k];
    endsequence

    sequence s_ctrl_write(int k);
        wr && idx == 4'(IDX_CTRL1 + 4'(k));
    endsequence

    for (genvar a = 0; a < N_CMP; a++) begin : g_chk
        ctrl_on_write_a: assert property (s_ctrl_write(a) |=> ana_o[a].on == $past(wb_dat_i[BIT_ON]))
            else $error("enable does not follow control write");
        irq_gate_a: assert property (cmp_irq_o[a] |-> st.ctrl[a].irq_on && st.flag[a])
            else $error("interrupt raised while disabled");
        toggle_hit_a: assert property (st.ctrl[a].on && st.ctrl[a].sense == SENSE_TOGGLE
            |-> hit[a] == $changed(lvl[a]))
            else $error("toggle sensitivity missed or invented an event");
        reserved_code_a: assert property (st.ctrl[a].sense == SENSE_RSVD |-> !hit[a])
            else $error("reserved sensitivity produced an event");
        fall_hit_a: assert property (st.ctrl[a].on && st.ctrl[a].sense == SENSE_FALL
            |-> hit[a] == $fell(lvl[a]))
            else $error("falling sensitivity mismatch");
        rise_hit_a: assert property (st.ctrl[a].on && st.ctrl[a].sense == SENSE_RISE
            |-> hit[a] == $rose(lvl[a]))
            else $error("rising sensitivity mismatch");
        negsel_write_a: assert property (s_ctrl_write(a) |=> ana_o[a].negsel == $past(wb_dat_i[2:0])
            && ana_o[a].ladder_sel == !$past(wb_dat_i[2]))
            else $error("negative input select does not follow write");
        pin_select_a: assert property (ana_o[a].own_negative_pin || ana_o[a].shared_negative_pin
            |-> ana_o[a].negsel[2:1] == 2'h3 && !ana_o[a].dac_sel && !ana_o[a].bandgap_sel)
            else $error("pin select decoded from wrong code");
        flag_set_a: assert property (hit[a] |=> st.flag[a] && (!st.ctrl[a].irq_on || cmp_irq_o[a]))
            else $error("event did not set the flag");
        flag_clear_a: assert property (s_status_clear(a) |=> !st.flag[a])
            else $error("write one did not clear the flag");
        invert_a: assert property ($past(st.econ[a].out_invert, 2) && !$past(rst_i) && !$past(rst_i, 2)
            |-> lvl[a] == !$past(cmp_raw_i[a], 2))
            else $error("inverted output does not match input");
    end

    dac_select_a: assert property (wr && idx == IDX_CTRL1 && wb_dat_i[2:0] == NEG_DAC |=> ana_o[0].dac_sel)
        else $error("converter select not decoded");
    alt_pin_a: assert property (alt_pin_o.oe |-> alt_pin_o.val == lvl[N_CMP-1])
        else $error("alternate pin carries wrong value");
    status_read_a: assert property (rd && idx == IDX_STATUS ##1 wb_ack_o
        |-> wb_dat_o[STAT_LEVEL_LSB +: N_CMP] == $past(lvl) && wb_dat_o[STAT_FLAG_LSB +: N_CMP] == $past(st.flag))
        else $error("status read does not show levels and flags");
    econ_write_a: assert property (wr && idx == IDX_ECON1 |=> st.econ[0].spare == 2'h0
        && st.econ[0].hyst == $past(wb_dat_i[2:0]))
        else $error("extended control write not stored");
    capture_off_a: assert property (!capture_route_o |-> !capture_o)
        else $error("capture path active while routing is off");
    level_read_a: assert property (rd && idx == IDX_STATUS |=> wb_dat_o[STAT_LEVEL_LSB] == $past(lvl[0]))
        else $error("level bit does not mirror output");
    reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
        st.ctrl == '0 && st.econ == '0 && !irq_o && ana_o[0].on == 1'b0)
        else $error("controls not cleared by reset");

endmodule

// >>> test/ccr_cmp_model.sv
// Behavioural model of the three analog comparator cores and their input muxes
module ccr_cmp_model
#(
    parameter int VREF_MV = 2560,
    parameter int BG_MV   = 1100,
    parameter int DAC_MV  = 1500,
    parameter int OWN_MV  = 800,
    parameter int SHR_MV  = 1000
)
(
    input  wire ccr_pkg::ccr_ana_s [ccr_pkg::N_CMP-1:0] ana_i,
    input  wire logic [ccr_pkg::N_CMP-1:0][15:0]        pos_i,
    output logic      [ccr_pkg::N_CMP-1:0]              raw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    // ------------------------------------------------------------------
    // Negative input mux and compare
    // ------------------------------------------------------------------
    localparam int DIV [4] = '{640, 320, 213, 160};
    int neg [N_CMP];
    always_comb begin
        for (int k = 0; k < N_CMP; k++) begin
            if (ana_i[k].ladder_sel) neg[k] = VREF_MV * 100 / DIV[ana_i[k].negsel[1:0]];
            else if (ana_i[k].bandgap_sel) neg[k] = BG_MV;
            else if (ana_i[k].dac_sel) neg[k] = DAC_MV;
            else if (ana_i[k].own_negative_pin) neg[k] = OWN_MV;
            else neg[k] = SHR_MV;
            // Ideal core: no offset, so thresholds are exact
            raw_o[k] = int'(pos_i[k]) > neg[k];
        end
    end
endmodule

// >>> test/ccr_top_tb.sv
// Self-checking bench for the comparator control register bank
module ccr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccr_pkg::*;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0]                 adr = 8'h00;
    logic [3:0]                 sel = 4'h0;
    logic [31:0]                wdat = '0, rdat, rd;
    logic [2:0]                 vec_ack = '0, cmp_irq, raw;
    logic [2:0][15:0]           pos = '0;
    ccr_ana_s [2:0]             ana;
    ccr_pin_s [2:0]             pins;
    ccr_pin_s                   alt;
    logic                       cap_route, cap, irq, er, ef;
    int                         n_mismatch = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    ccr_top ccr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cmp_raw_i(raw), .vec_ack_i(vec_ack), .ana_o(ana), .out_pin_o(pins), .alt_pin_o(alt),
        .capture_route_o(cap_route), .capture_o(cap), .cmp_irq_o(cmp_irq), .irq_o(irq));
    ccr_cmp_model ccr_cmp_model_i (.ana_i(ana), .pos_i(pos), .raw_o(raw));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until ack is sampled, then releases
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int t;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h00_0000, d}; sel <= 4'hF;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        // A slave that never answers ends the run here
        if (t >= 50) begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, {24'h00_0000, e});
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    localparam logic [7:0] WA [4] = '{8'h00, 8'h08, 8'h0C, 8'h10};
    localparam logic [7:0] WE [4] = '{8'hF7, 8'hFF, 8'h3F, 8'h37};
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), (i == 7) ? 8'hE0 : 8'h00);
        rdc(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(WA[i], 8'hFF);
            rdc(WA[i], WE[i]);
        end
        repeat (4) @(posedge clk_i);
        chk(pins[0], 2'b11);
        chk(ana[0].hyst, 3'h7);
        chk({cap_route, cap}, 2'b11);
        chk(alt, 2'b01);
        chk(irq, 1'b1);
        rdc(8'h18, 8'h26);
        for (int i = 0; i < 4; i++) wr(WA[i], 8'h00);
        repeat (4) @(posedge clk_i);
        wr(8'h18, 8'hE0);
        rdc(8'h18, 8'h00);
        // Ladder 400/800/1201/1600, bandgap 1100, dac 1500, pins 800/1000 against 900
        pos[0] <= 16'd900;
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, 8'(c));
            repeat (4) @(posedge clk_i);
            chk(ana[0].negsel, 32'(c));
            chk(ana[0].on, 1'b0);
            chk({ana[0].ladder_sel, ana[0].bandgap_sel, ana[0].dac_sel, ana[0].own_negative_pin,
                 ana[0].shared_negative_pin}, (c < 4) ? 5'h10 : 5'(5'h10 >> (c - 3)));
            wb(1'b0, 8'h18, 8'h00, rd);
            chk(rd[1], 1'((8'h43 >> c) & 1));
        end
        pos[0] <= 16'd0;
        wr(8'h00, 8'h87);
        chk(ana[0].on, 1'b1);
        for (int s = 0; s < 4; s++) begin
            er = (s == 0 || s == 3);
            ef = (s == 0 || s == 2);
            wr(8'h00, 8'(8'hC7 | (s << 4)));
            pos[0] <= 16'd2000;
            repeat (5) @(posedge clk_i);
            chk(irq, er);
            wr(8'h18, 8'h20);
            rdc(8'h18, 8'h02);
            pos[0] <= 16'd0;
            repeat (5) @(posedge clk_i);
            chk(irq, ef);
            wr(8'h18, 8'h20);
        end
        wr(8'h04, 8'h87);
        pos[1] <= 16'd2000;
        repeat (5) @(posedge clk_i);
        chk({cmp_irq, irq}, 4'h0);
        rdc(8'h18, 8'h44);
        wr(8'h04, 8'hC7);
        chk({cmp_irq, irq}, 4'h5);
        wr(8'h1C, 8'h00);
        chk(irq, 1'b0);
        wr(8'h1C, 8'hE0);
        vec_ack[1] <= 1'b1;
        @(posedge clk_i);
        vec_ack[1] <= 1'b0;
        @(posedge clk_i);
        chk(cmp_irq, 3'b000);
        wr(8'h04, 8'h87);
        pos[1] <= 16'd0;
        repeat (5) @(posedge clk_i);
        vec_ack[1] <= 1'b1;
        @(posedge clk_i);
        vec_ack[1] <= 1'b0;
        rdc(8'h18, 8'h40);
        wr(8'h18, 8'h40);
        // Comparator 3 powered down before its input moves
        wr(8'h08, 8'h07);
        pos[2] <= 16'd2000;
        repeat (5) @(posedge clk_i);
        rdc(8'h18, 8'h08);
        chk(alt, 2'b10);
        wr(8'h08, 8'h0F);
        chk(alt, 2'b11);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
